/* File: pcs_params.svh */
// Constants of the program-flow and indirect addressing unit
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH
`define PCS_PC_W 13
`define PCS_PAGE_LSB 11
`define PCS_DEPTH 8
`define PCS_SP_W 3
`define PCS_ADDR_INDIRECT 7'h00
`define PCS_ADDR_PCLOW 7'h02
`define PCS_ADDR_POINTER 7'h04
`define PCS_ADDR_LATCH 7'h0A
`define PCS_IRQ_VECTOR 13'h0004
`define PCS_PC_RST 13'h0000
`define PCS_LATCH_RST 8'h00
`define PCS_PTR_RST 8'h00
`define PCS_LATCH_IMPL 8'h1F
`endif

/* File: pcs_pkg.sv */
// Types of the program-flow and indirect addressing unit
`include "pcs_params.svh"
package pcs_pkg;
   // Flow commands from the instruction decoder
   typedef struct packed {
      logic step;
      logic jump;
      logic call;
      logic irq;
      logic ret;
      logic [10:0] target;
   } pcs_flow_t;
   // Data-space access, direct 9-bit address
   typedef struct packed {
      logic rd;
      logic wr;
      logic [8:0] addr;
      logic [7:0] wdata;
   } pcs_acc_t;
   // Stack action of one cycle
   typedef enum logic [1:0] {
      PCS_STK_NONE = 2'b00,
      PCS_STK_PUSH = 2'b01,
      PCS_STK_POP = 2'b10
   } pcs_stk_t;
endpackage

/* File: pcs_unit.sv */
// Program counter, return stack and indirect addressing unit
`timescale 1ns/1ps
`include "pcs_params.svh"
module pcs_unit (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire pcs_pkg::pcs_flow_t flow_i,
   input wire pcs_pkg::pcs_acc_t acc_i,
   input wire logic bank_bit_i,
   output logic [12:0] pc_o,
   output pcs_pkg::pcs_acc_t ext_o,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o
);
   import pcs_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [`PCS_PC_W-1:0] pc;
   logic [7:0] pc_high_latch;
   logic [7:0] pointer_select_reg;
   logic [`PCS_SP_W-1:0] sp;
   logic [`PCS_PC_W-1:0] stack_mem [0:`PCS_DEPTH-1];
   pcs_acc_t ext;
   logic [7:0] rd_data;
   logic rd_valid;

   // ----------------------------------------
   // Indirect address formation
   // ----------------------------------------
   logic is_indirect;
   logic [8:0] eff_addr;
   logic [6:0] eff_low;
   logic self_point;

   // Indirect port has no storage, it redirects
   assign is_indirect = (acc_i.addr[6:0] == `PCS_ADDR_INDIRECT);
   // Bank bit above pointer value
   assign eff_addr = is_indirect ? {bank_bit_i, pointer_select_reg}
                                 : acc_i.addr;
   assign eff_low = eff_addr[6:0];
   // Pointer at indirect port itself
   assign self_point = is_indirect && (pointer_select_reg == 8'h00);

   // ----------------------------------------
   // Local register decode
   // ----------------------------------------
   logic hit_pcl;
   logic hit_latch;
   logic hit_ptr;
   logic hit_local;
   logic wr_pcl;
   logic wr_latch;
   logic wr_ptr;
   logic rd_any;

   assign hit_pcl = (eff_low == `PCS_ADDR_PCLOW);
   assign hit_latch = (eff_low == `PCS_ADDR_LATCH);
   assign hit_ptr = (eff_low == `PCS_ADDR_POINTER);
   assign hit_local = hit_pcl || hit_latch || hit_ptr || self_point;
   // Self-pointed write stores nothing
   assign wr_pcl = acc_i.wr && hit_pcl && !self_point;
   assign wr_latch = acc_i.wr && hit_latch && !self_point;
   assign wr_ptr = acc_i.wr && hit_ptr && !self_point;
   assign rd_any = acc_i.rd && hit_local;

   // Local read value; upper counter bits never exposed
   logic [7:0] local_rd;
   assign local_rd = self_point ? 8'h00 :
                     hit_pcl ? pc[7:0] :
                     hit_latch ? (pc_high_latch & `PCS_LATCH_IMPL) :
                     hit_ptr ? pointer_select_reg : 8'h00;

   // ----------------------------------------
   // Stack control
   // ----------------------------------------
   pcs_stk_t stk_op;
   logic [`PCS_SP_W-1:0] sp_dec;
   logic [`PCS_PC_W-1:0] stack_top;

   // Push on call or interrupt, pop on a return with neither in the same cycle
   assign stk_op = (flow_i.irq || flow_i.call) ? PCS_STK_PUSH :
                   flow_i.ret ? PCS_STK_POP : PCS_STK_NONE;
   // Pointer wraps freely, no over- or underflow flag
   assign sp_dec = sp - 3'h1;
   assign stack_top = stack_mem[sp_dec];

   // ----------------------------------------
   // Next program counter
   // ----------------------------------------
   logic [`PCS_PC_W-1:0] pc_inc;
   logic [`PCS_PC_W-1:0] pc_branch;
   logic [`PCS_PC_W-1:0] pc_pclw;
   logic [`PCS_PC_W-1:0] next_pc;

   // Full 13-bit increment with carry into upper bits
   assign pc_inc = pc + 13'h0001;
   // Page bits from latch, offset from instruction
   assign pc_branch = {pc_high_latch[4:3], flow_i.target};
   // Low byte write loads upper bits from latch
   assign pc_pclw = {pc_high_latch[4:0], acc_i.wdata};

   // Priority: interrupt, return, call/jump, low write, step
   always_comb begin
      next_pc = pc;
      if (flow_i.irq) begin
         next_pc = `PCS_IRQ_VECTOR;
      end else if (flow_i.ret) begin
         next_pc = stack_top;
      end else if (flow_i.call || flow_i.jump) begin
         next_pc = pc_branch;
      end else if (wr_pcl) begin
         next_pc = pc_pclw;
      end else if (flow_i.step) begin
         next_pc = pc_inc;
      end
   end

   // ----------------------------------------
   // Program counter register
   // ----------------------------------------
   // Reset clears the whole counter, upper bits included
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pc <= `PCS_PC_RST;
      end else begin
         pc <= next_pc;
      end
   end

   // ----------------------------------------
   // Latch and pointer registers
   // ----------------------------------------
   // Latch changes only by software write, never by stack
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pc_high_latch <= `PCS_LATCH_RST;
      end else if (wr_latch) begin
         pc_high_latch <= acc_i.wdata & `PCS_LATCH_IMPL;
      end
   end

   // Pointer select register
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pointer_select_reg <= `PCS_PTR_RST;
      end else if (wr_ptr) begin
         pointer_select_reg <= acc_i.wdata;
      end
   end

   // ----------------------------------------
   // Return stack
   // ----------------------------------------
   // Hidden pointer, no software path to it
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sp <= '0;
      end else begin
         case (stk_op)
            PCS_STK_PUSH: begin
               sp <= sp + 3'h1;
            end
            PCS_STK_POP: begin
               sp <= sp_dec;
            end
            default: begin
               sp <= sp;
            end
         endcase
      end
   end

   // One entry per level, written on push at the pointer
   genvar gi;
   generate
      for (gi = 0; gi < `PCS_DEPTH; gi = gi + 1) begin : g_stk
         logic hit;
         assign hit = (stk_op == PCS_STK_PUSH) && (sp == `PCS_SP_W'(gi));
         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               stack_mem[gi] <= `PCS_PC_RST;
            end else if (hit) begin
               stack_mem[gi] <= pc;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Data-space answer
   // ----------------------------------------
   // Non-local accesses go out at the effective address
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ext <= '0;
      end else begin
         ext.rd <= acc_i.rd && !hit_local;
         ext.wr <= acc_i.wr && !hit_local;
         ext.addr <= eff_addr;
         ext.wdata <= acc_i.wdata;
      end
   end

   // Local read data, one cycle after the access
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_data <= rd_any ? local_rd : 8'h00;
         rd_valid <= rd_any;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign pc_o = pc;
   assign ext_o = ext;
   assign rd_data_o = rd_data;
   assign rd_valid_o = rd_valid;
endmodule

/* File: pcs_unit_props.sv */
// Port assertions of the program-flow unit
`timescale 1ns/1ps
module pcs_unit_props (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire pcs_pkg::pcs_flow_t flow_i,
   input wire pcs_pkg::pcs_acc_t acc_i,
   input wire logic bank_bit_i,
   input wire logic [12:0] pc_o,
   input wire pcs_pkg::pcs_acc_t ext_o,
   input wire logic [7:0] rd_data_o,
   input wire logic rd_valid_o
);
   import pcs_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // Any flow command that outranks a low-byte write
   wire logic brk = flow_i.jump | flow_i.call | flow_i.irq | flow_i.ret;
   wire logic lcl = acc_i.addr[6:0] inside {7'h00, 7'h02, 7'h04, 7'h0A};
   a_step_incr: assert property (flow_i.step && !brk && !acc_i.wr |=> pc_o == $past(pc_o) + 13'h1)
      else $error("step wrong");
   a_jump_low: assert property ((flow_i.jump || flow_i.call) && !flow_i.irq && !flow_i.ret
      |=> pc_o[10:0] == $past(flow_i.target)) else $error("jump wrong");
   a_irq_vector: assert property (flow_i.irq |=> pc_o == 13'h0004)
      else $error("vector wrong");
   a_low_write: assert property (acc_i.wr && acc_i.addr[6:0] == 7'h02 && !brk
      |=> pc_o[7:0] == $past(acc_i.wdata)) else $error("low write wrong");
   a_low_read: assert property (acc_i.rd && acc_i.addr[6:0] == 7'h02
      |=> rd_valid_o && rd_data_o == $past(pc_o[7:0])) else $error("low read wrong");
   a_valid_cause: assert property (rd_valid_o |-> $past(acc_i.rd))
      else $error("stray valid");
   a_ext_write: assert property (ext_o.wr |-> $past(acc_i.wr) && ext_o.wdata == $past(acc_i.wdata))
      else $error("stray write");
   a_ext_read: assert property (acc_i.rd && !lcl |=> ext_o.rd && ext_o.addr == $past(acc_i.addr))
      else $error("direct read wrong");
endmodule

/* File: pcs_decode_model.sv */
// Behavioural decoder that turns bench commands into flow requests
`timescale 1ns/1ps
module pcs_decode_model (
   input wire logic [4:0] kind_i,
   input wire logic [10:0] target_i,
   output pcs_pkg::pcs_flow_t flow_o
);
   import pcs_pkg::*;
   // Kind is step, jump, call, irq, return; page bits are set by the bench first
   assign flow_o = {kind_i, target_i};
endmodule

/* File: pcs_unit_test.sv */
// Self-checking bench of the program-flow unit
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
   $display("mismatch %0t got %h exp %h", $time, a, b); end end
module pcs_unit_test;
   import pcs_pkg::*;
   logic mclk_i = 0, rst_i = 1, bank_bit_i = 0;
   logic [4:0] kind = '0;
   logic [10:0] tgt = '0;
   pcs_acc_t acc_i = '0, ext_o;
   pcs_flow_t flow_i;
   logic [12:0] pc_o;
   logic [7:0] rd_data_o;
   logic rd_valid_o;
   int err_count = 0, n_checks = 0;
   localparam logic [4:0] ST = 5'h10, JP = 5'h08, CL = 5'h04, IQ = 5'h02, RT = 5'h01;
   always #12.5 mclk_i = ~mclk_i;
   pcs_decode_model i_pcs_decode_model (.kind_i(kind), .target_i(tgt), .flow_o(flow_i));
   pcs_unit i_pcs_unit (.mclk_i, .rst_i, .flow_i, .acc_i, .bank_bit_i, .pc_o, .ext_o,
      .rd_data_o, .rd_valid_o);
   function pcs_acc_t ac(logic r, logic w, logic [8:0] ad, logic [7:0] d);
      return {r, w, ad, d};
   endfunction
   // One command cycle, then idle; outputs show its result on return
   task op(input logic [4:0] k, input logic [10:0] t, input pcs_acc_t a);
      @(posedge mclk_i) #1;
      kind = k;
      tgt = t;
      acc_i = a;
      @(posedge mclk_i) #1;
      kind = '0;
      acc_i = '0;
   endtask
   task t_branch;
      op(0, 0, ac(0, 1, 9'h00A, 8'h18));
      op(JP, 11'h123, '0);
      `CHK(pc_o, 13'h1923)
      op(CL, 11'h055, '0);
      `CHK(pc_o, 13'h1855)
      op(RT, 0, '0);
      `CHK(pc_o, 13'h1923)
      op(0, 0, ac(1, 0, 9'h00A, 0));
      `CHK(rd_data_o, 8'h18)
      op(ST, 0, ac(0, 1, 9'h002, 8'h5A));
      `CHK(pc_o, 13'h185A)
      op(ST, 0, '0);
      `CHK(pc_o, 13'h185B)
      op(0, 0, ac(1, 0, 9'h102, 0));
      `CHK({rd_valid_o, rd_data_o}, 9'h15B)
      op(IQ, 0, '0);
      `CHK(pc_o, 13'h0004)
      op(RT, 0, '0);
      `CHK(pc_o, 13'h185B)
   endtask
   // Nine calls, then nine returns; the last return finds the wrapped entry
   task t_wrap;
      for (int i = 1; i <= 9; i++) op(CL, 11'(i), '0);
      for (int i = 8; i >= 0; i--) begin
         op(RT, 0, '0);
         `CHK(pc_o, {2'b11, 11'(i == 0 ? 8 : i)})
      end
   endtask
   task t_indirect;
      bank_bit_i = 1;
      op(0, 0, ac(0, 1, 9'h004, 8'h25));
      op(0, 0, ac(1, 0, 9'h000, 0));
      `CHK({ext_o.rd, ext_o.addr}, 10'h325)
      op(0, 0, ac(0, 1, 9'h030, 8'h77));
      `CHK({ext_o.wr, ext_o.addr, ext_o.wdata}, 18'h23077)
      op(0, 0, ac(0, 1, 9'h004, 8'h00));
      op(0, 0, ac(1, 0, 9'h000, 0));
      `CHK({rd_valid_o, rd_data_o, ext_o.rd}, 10'h200)
      op(0, 0, ac(0, 1, 9'h100, 8'h99));
      `CHK(ext_o.wr, 1'b0)
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge mclk_i);
      #1 rst_i = 0;
      `CHK(pc_o, 13'h0000)
      t_branch;
      t_wrap;
      t_indirect;
      rst_i = 1;
      #30 `CHK(pc_o, 13'h0000)
      @(posedge mclk_i) #1 rst_i = 0;
      op(ST, 0, '0);
      `CHK(pc_o, 13'h0001)
      conclude;
   end
   // Watchdog against a hang
   initial begin
      #20us;
      err_count++;
      conclude;
   end
endmodule
bind pcs_unit pcs_unit_props i_pcs_unit_props (.mclk_i, .rst_i, .flow_i, .acc_i, .bank_bit_i,
   .pc_o, .ext_o, .rd_data_o, .rd_valid_o);
